// ===== sfcf_frontend.v
// What this block does
// RULE_01 - Decode 24-bit addresses up to 07FFFFh; report sector, 32K and 64K block numbers.
// RULE_02 - Unknown opcode: standby, output released until next chip select fall.
// RULE_03 - Valid opcode: stay active until chip select rises.
// RULE_04 - Sample inputs on rising serial clock, shift outputs on falling; modes 0 and 3.
// RULE_05 - Host picks mode by idle clock level and phase.
// RULE_06 - Read-type commands may end after any output bit, cleanly.
// RULE_07 - Write-type commands need chip select rise on byte boundary, else rejected.
// RULE_08 - While busy, array accesses are ignored; running operation continues.
// RULE_09 - Host reads status before each command.
// RULE_10 - Maker/device code: two dummies, address byte 0 or 1 chooses first code.
// RULE_11 - AB alone wakes from deep sleep; with three dummies returns signature.
// RULE_12 - Host avoids undefined opcodes.
// RULE_13 - Reset needs 66h then 99h directly; anything between cancels it.
// RULE_14 - 06h framed alone sets the write latch; upper I/O ignored.
// RULE_15 - Host issues write-enable before every program, erase or status write.
// RULE_16 - 04h framed alone clears the write latch.
// RULE_17 - Latch clears at power-up and on completion of disable, write, program, erases.
// RULE_18 - Decode single-line command set including fast reads with eight dummy cycles.
// RULE_19 - With latch clear, program, erase and status write are refused.
// RULE_20 - Chip erase only when all four block-protect bits are zero.
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_regs.vh"
module sfcf_frontend #(
  parameter [7:0] SIG_ID = 8'h5a,
  parameter [7:0] MAKER_ID = 8'ha5,
  parameter [7:0] DEV_ID = 8'h3c,
  parameter [23:0] JEDEC_ID = 24'h123456
) (
  input wire clk_sys,
  input wire resetn,
  input wire chip_sel_n,
  input wire serial_clk,
  input wire data_line_0_in,
  input wire data_line_1_in,
  output reg data_line_0_out,
  output reg data_line_0_oe,
  output reg data_line_1_out,
  output reg data_line_1_oe,
  input wire [7:0] status_byte,
  input wire busy,
  input wire [3:0] protect_bits,
  output reg write_latch_flag,
  output reg deep_sleep,
  output reg [7:0] cmd_opcode,
  output reg [23:0] cmd_addr,
  output reg [6:0] cmd_sector,
  output reg [3:0] cmd_blk32,
  output reg [2:0] cmd_blk64,
  output reg cmd_exec,
  output reg rd_req,
  input wire [7:0] rd_data,
  output reg wr_strobe,
  output reg [7:0] wr_data,
  output reg soft_reset
);
  // ============================================
  // Pin synchronisers and edge detection
  wire [2:0] pins_s;
  wire cs_s = pins_s[2];
  wire sck_s = pins_s[1];
  wire din_s = pins_s[0];
  reg cs_q, sck_q;
  sfcf_sync #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in({chip_sel_n, serial_clk, data_line_0_in}),
    // Idle levels: select high, clock and data low, matching sck_q after reset
    .rst_val(3'h4),
    .sync_out(pins_s)
  );
  wire cs_fall = cs_q & ~cs_s;
  wire cs_rise = ~cs_q & cs_s;
  // Mode 0 or 3: first rising edge after select samples in both; the mode 3 fall before it is ignored
  wire sck_rise = ~cs_s & ~sck_q & sck_s; // RULE_04 RULE_05
  wire sck_fall = ~cs_s & sck_q & ~sck_s; // RULE_04 RULE_05
  // ============================================
  // Frame state
  localparam ST_OP = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DUMMY = 3'h2;
  localparam ST_OUT = 3'h3;
  localparam ST_IN = 3'h4;
  localparam ST_DONE = 3'h5;
  localparam ST_STBY = 3'h6;
  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [1:0] nbytes_q;
  reg [3:0] dcnt_q;
  reg [7:0] obyte_q;
  reg [1:0] oidx_q;
  reg [8:0] pcnt_q;
  reg arm_q;
  reg dual_q;
  wire [7:0] byte_in = {sh_q[6:0], din_s};
  wire byte_end = sck_rise & (bit_q == 3'h7);
  // ============================================
  // Command classification
  reg known, is_rd, needs_wel, has_addr, has_dummy, nofr;
  always @* begin
    known = 1'b1;
    is_rd = 1'b0;
    needs_wel = 1'b0;
    has_addr = 1'b0;
    has_dummy = 1'b0;
    nofr = 1'b0;
    case (byte_in) // RULE_18
      `SFCF_OP_READ: begin is_rd = 1'b1; has_addr = 1'b1; end
      `SFCF_OP_FAST, `SFCF_OP_DUAL, `SFCF_OP_SFDP: begin
        is_rd = 1'b1; has_addr = 1'b1; has_dummy = 1'b1;
      end
      `SFCF_OP_PROG, `SFCF_OP_SE, `SFCF_OP_BE32, `SFCF_OP_BE64: begin
        needs_wel = 1'b1; has_addr = 1'b1;
      end
      `SFCF_OP_CE1, `SFCF_OP_CE2, `SFCF_OP_STATUS_WRITE_CMD: needs_wel = 1'b1;
      `SFCF_OP_MAKER_DEVICE_CODE_CMD: has_addr = 1'b1;
      `SFCF_OP_IDENTITY_READ_CMD, `SFCF_OP_STATUS_READ_CMD: is_rd = 1'b1;
      `SFCF_OP_RES: nofr = 1'b1;
      `SFCF_OP_WRITE_ENABLE_CMD, `SFCF_OP_WRITE_DISABLE_CMD, `SFCF_OP_DP, `SFCF_OP_FACTORY_SPEEDUP_CMD,
      `SFCF_OP_RESET_ARM_CMD, `SFCF_OP_RST: nofr = 1'b1;
      default: known = 1'b0;
    endcase
  end
  // Array access while busy is simply not decoded
  wire array_cmd = has_addr & (byte_in != `SFCF_OP_MAKER_DEVICE_CODE_CMD);
  wire accept = known & ~(deep_sleep & byte_in != `SFCF_OP_RES)
    & ~(busy & (array_cmd | needs_wel)) // RULE_08
    & ~(needs_wel & ~write_latch_flag) // RULE_19
    & ~((byte_in == `SFCF_OP_CE1 || byte_in == `SFCF_OP_CE2)
      & (protect_bits != 4'h0)); // RULE_20
  // Write-type commands run only if chip select rises on a byte boundary
  wire nobyte = (bit_q == 3'h0);
  wire wr_type = (cmd_opcode == `SFCF_OP_WRITE_ENABLE_CMD) | (cmd_opcode == `SFCF_OP_WRITE_DISABLE_CMD)
    | (cmd_opcode == `SFCF_OP_STATUS_WRITE_CMD) | (cmd_opcode == `SFCF_OP_PROG)
    | (cmd_opcode == `SFCF_OP_SE) | (cmd_opcode == `SFCF_OP_BE32)
    | (cmd_opcode == `SFCF_OP_BE64) | (cmd_opcode == `SFCF_OP_CE1)
    | (cmd_opcode == `SFCF_OP_CE2) | (cmd_opcode == `SFCF_OP_DP);
  wire frame_ok = (st_q == ST_DONE) | ((st_q == ST_IN) & (pcnt_q != 9'h0));
  wire commit = cs_rise & frame_ok & nobyte & wr_type; // RULE_07
  // Next output byte for id and status reads
  function [7:0] next_byte;
    input [7:0] op;
    input [1:0] idx;
    input [7:0] a;
    begin
      case (op)
        `SFCF_OP_STATUS_READ_CMD: next_byte = status_byte;
        `SFCF_OP_RES: next_byte = SIG_ID;
        `SFCF_OP_MAKER_DEVICE_CODE_CMD: next_byte = (a[0] ^ idx[0]) ? DEV_ID : MAKER_ID; // RULE_10
        `SFCF_OP_IDENTITY_READ_CMD: next_byte = (idx == 2'h0) ? JEDEC_ID[23:16] :
          (idx == 2'h1) ? JEDEC_ID[15:8] : JEDEC_ID[7:0];
        default: next_byte = rd_data;
      endcase
    end
  endfunction
  // Word picked once per byte; bits sliced on purpose below
  wire [7:0] out_word = next_byte(cmd_opcode, oidx_q, cmd_addr[7:0]);
  // ============================================
  // Main sequencer
  always @(posedge clk_sys) begin
    if (!resetn) begin
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      st_q <= ST_STBY;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      nbytes_q <= 2'h0;
      dcnt_q <= 4'h0;
      obyte_q <= 8'h00;
      oidx_q <= 2'h0;
      pcnt_q <= 9'h0;
      arm_q <= 1'b0;
      dual_q <= 1'b0;
      write_latch_flag <= `SFCF_WEL_RESET; // RULE_17
      deep_sleep <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_addr <= 24'h000000;
      cmd_sector <= 7'h00;
      cmd_blk32 <= 4'h0;
      cmd_blk64 <= 3'h0;
      cmd_exec <= 1'b0;
      rd_req <= 1'b0;
      wr_strobe <= 1'b0;
      wr_data <= 8'h00;
      soft_reset <= 1'b0;
      data_line_0_out <= 1'b0;
      data_line_0_oe <= 1'b0;
      data_line_1_out <= 1'b0;
      data_line_1_oe <= 1'b0;
    end else begin
      cs_q <= cs_s;
      sck_q <= sck_s;
      cmd_exec <= 1'b0;
      rd_req <= 1'b0;
      wr_strobe <= 1'b0;
      soft_reset <= 1'b0;
      if (cs_fall) begin
        st_q <= ST_OP;
        bit_q <= 3'h0;
      end else if (cs_rise) begin
        // Read-type ends cleanly at any bit
        data_line_0_oe <= 1'b0; // RULE_06
        data_line_1_oe <= 1'b0;
        st_q <= ST_STBY; // RULE_03
        bit_q <= 3'h0;
        if (commit) begin
          cmd_exec <= 1'b1;
          case (cmd_opcode)
            `SFCF_OP_WRITE_ENABLE_CMD: write_latch_flag <= 1'b1; // RULE_14
            `SFCF_OP_WRITE_DISABLE_CMD: write_latch_flag <= 1'b0; // RULE_16 RULE_17
            `SFCF_OP_DP: deep_sleep <= 1'b1;
            default: write_latch_flag <= 1'b0; // RULE_17
          endcase
        end else if (st_q != ST_OP && st_q != ST_STBY && nobyte) begin
          // Bare wake opcode ends in the address phase, not in the done state
          if (cmd_opcode == `SFCF_OP_RES) deep_sleep <= 1'b0; // RULE_11
          if (st_q == ST_DONE) begin
            if (cmd_opcode == `SFCF_OP_RST && arm_q) soft_reset <= 1'b1; // RULE_13
            if (cmd_opcode == `SFCF_OP_FACTORY_SPEEDUP_CMD) cmd_exec <= 1'b1;
          end
        end
        if (st_q != ST_STBY)
          arm_q <= (cmd_opcode == `SFCF_OP_RESET_ARM_CMD) && (st_q == ST_DONE) && nobyte; // RULE_13
      end else if (sck_rise && st_q != ST_STBY) begin
        sh_q <= byte_in;
        // Output phase counts falling edges only, else each byte halves
        if (st_q != ST_OUT) bit_q <= bit_q + 3'h1;
        case (st_q)
          ST_OP: if (byte_end) begin
            cmd_opcode <= byte_in;
            nbytes_q <= 2'h0;
            oidx_q <= 2'h0;
            pcnt_q <= 9'h0;
            dual_q <= (byte_in == `SFCF_OP_DUAL);
            if (!accept) begin
              st_q <= ST_STBY; // RULE_02
              arm_q <= 1'b0;
            end else if (has_addr || byte_in == `SFCF_OP_RES) st_q <= ST_ADDR;
            else if (is_rd) st_q <= ST_OUT;
            else if (byte_in == `SFCF_OP_STATUS_WRITE_CMD) st_q <= ST_IN;
            else st_q <= ST_DONE;
          end
          ST_ADDR: if (byte_end) begin
            cmd_addr <= {cmd_addr[15:0], byte_in};
            nbytes_q <= nbytes_q + 2'h1;
            if (nbytes_q == 2'h2) begin
              if (cmd_opcode == `SFCF_OP_FAST || cmd_opcode == `SFCF_OP_DUAL ||
                  cmd_opcode == `SFCF_OP_SFDP) begin
                st_q <= ST_DUMMY;
                dcnt_q <= 4'h0;
              end else if (cmd_opcode == `SFCF_OP_READ || cmd_opcode == `SFCF_OP_RES ||
                           cmd_opcode == `SFCF_OP_MAKER_DEVICE_CODE_CMD) begin
                st_q <= ST_OUT;
                rd_req <= (cmd_opcode == `SFCF_OP_READ);
              end else if (cmd_opcode == `SFCF_OP_PROG) st_q <= ST_IN;
              else st_q <= ST_DONE;
              // Earlier bytes still sit eight bits low until this byte lands
              cmd_sector <= cmd_addr[`SFCF_SECTOR_LSB-2:`SFCF_SECTOR_LSB-8]; // RULE_01
              cmd_blk32 <= cmd_addr[`SFCF_BLK32_LSB-5:`SFCF_BLK32_LSB-8]; // RULE_01
              cmd_blk64 <= cmd_addr[`SFCF_BLK64_LSB-6:`SFCF_BLK64_LSB-8]; // RULE_01
            end
          end
          ST_DUMMY: begin
            bit_q <= 3'h0;
            dcnt_q <= dcnt_q + 4'h1;
            if (dcnt_q == `SFCF_DUMMY_CYCLES - 4'h1) begin // RULE_18
              st_q <= ST_OUT;
              rd_req <= 1'b1;
            end
          end
          ST_IN: if (byte_end) begin
            wr_data <= byte_in;
            if (pcnt_q != `SFCF_PAGE_BYTES) begin
              wr_strobe <= 1'b1;
              pcnt_q <= pcnt_q + 9'h1;
            end
            if (cmd_opcode == `SFCF_OP_STATUS_WRITE_CMD) st_q <= ST_DONE;
          end
          ST_DONE: ;
          default: ;
        endcase
      end else if (sck_fall && st_q == ST_OUT) begin
        // Falling edge shifts out, first bit of each byte loads the next word
        bit_q <= dual_q ? bit_q + 3'h2 : bit_q + 3'h1;
        if (bit_q == 3'h0) begin
          obyte_q <= dual_q ? {out_word[5:0], 2'h0} : {out_word[6:0], 1'h0};
          data_line_1_out <= out_word[7];
          data_line_0_out <= out_word[6];
          // Code pair alternates, identity triple cycles
          oidx_q <= (oidx_q == 2'h2 || (cmd_opcode == `SFCF_OP_MAKER_DEVICE_CODE_CMD && oidx_q == 2'h1)) ?
            2'h0 : oidx_q + 2'h1;
          rd_req <= 1'b1;
        end else begin
          obyte_q <= dual_q ? {obyte_q[5:0], 2'h0} : {obyte_q[6:0], 1'h0};
          data_line_1_out <= obyte_q[7];
          data_line_0_out <= obyte_q[6];
        end
        data_line_1_oe <= 1'b1;
        data_line_0_oe <= dual_q;
      end else if (sck_rise) begin
        bit_q <= bit_q;
      end
    end
  end
endmodule // sfcf_frontend
`default_nettype wire

// ===== sfcf_regs.vh
`ifndef SFCF_REGS_VH
`define SFCF_REGS_VH
// ============================================
// Opcodes
`define SFCF_OP_READ 8'h03
`define SFCF_OP_FAST 8'h0b
`define SFCF_OP_DUAL 8'h3b
`define SFCF_OP_PROG 8'h02
`define SFCF_OP_SE 8'h20
`define SFCF_OP_BE32 8'h52
`define SFCF_OP_BE64 8'hd8
`define SFCF_OP_CE1 8'h60
`define SFCF_OP_CE2 8'hc7
`define SFCF_OP_SFDP 8'h5a
`define SFCF_OP_WRITE_ENABLE_CMD 8'h06
`define SFCF_OP_WRITE_DISABLE_CMD 8'h04
`define SFCF_OP_DP 8'hb9
`define SFCF_OP_FACTORY_SPEEDUP_CMD 8'h41
`define SFCF_OP_RESET_ARM_CMD 8'h66
`define SFCF_OP_RST 8'h99
`define SFCF_OP_IDENTITY_READ_CMD 8'h9f
`define SFCF_OP_RES 8'hab
`define SFCF_OP_MAKER_DEVICE_CODE_CMD 8'h90
`define SFCF_OP_STATUS_READ_CMD 8'h05
`define SFCF_OP_STATUS_WRITE_CMD 8'h01
// ============================================
// Array layout and framing
`define SFCF_ADDR_TOP 24'h07ffff
`define SFCF_SECTOR_LSB 12
`define SFCF_BLK32_LSB 15
`define SFCF_BLK64_LSB 16
`define SFCF_PAGE_BYTES 9'h100
`define SFCF_DUMMY_CYCLES 4'h8
`define SFCF_WEL_RESET 1'b0
`endif

// ===== sfcf_sync.v
`timescale 1ns/1ps
`default_nettype none
// ============================================
// Two-flop synchroniser, one per bit
module sfcf_sync #(
  parameter W = 3
) (
  input wire clk_sys,
  input wire resetn,
  input wire [W-1:0] async_in,
  input wire [W-1:0] rst_val,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_sys) begin
        if (!resetn) begin
          meta_q[i] <= rst_val[i];
          sync_out[i] <= rst_val[i];
        end else begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // sfcf_sync
`default_nettype wire

// ===== sfcf_frontend_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module sfcf_frontend_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic chip_sel_n,
  input wire logic data_line_1_oe,
  input wire logic [3:0] protect_bits,
  input wire logic write_latch_flag,
  input wire logic [7:0] cmd_opcode,
  input wire logic [23:0] cmd_addr,
  input wire logic [6:0] cmd_sector,
  input wire logic [2:0] cmd_blk64,
  input wire logic cmd_exec,
  input wire logic soft_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_EXEC_PULSE: assert property (cmd_exec |=> !cmd_exec)
    else $error("commit pulse too long");
  AST_EXEC_AT_RISE: assert property (cmd_exec |-> chip_sel_n && !$past(chip_sel_n, 8))
    else $error("commit not tied to select rise");
  AST_LATCH_SET: assert property ($rose(write_latch_flag) |-> chip_sel_n && cmd_opcode == 8'h06)
    else $error("latch set without framed enable");
  AST_LATCH_CLR: assert property ($fell(write_latch_flag) |-> chip_sel_n)
    else $error("latch cleared inside a frame");
  AST_WRITE_NEEDS_LATCH:
    assert property (cmd_exec && cmd_opcode inside {8'h02, 8'h20, 8'h52, 8'hd8, 8'h01}
      |-> $past(write_latch_flag)) else $error("write commit with latch clear");
  AST_CE_PROTECT:
    assert property (cmd_exec && (cmd_opcode == 8'h60 || cmd_opcode == 8'hc7)
      |-> protect_bits == 4'h0) else $error("chip erase while protected");
  AST_SECTOR_SPLIT:
    assert property (cmd_exec && cmd_opcode == 8'h20
      |-> cmd_sector == cmd_addr[18:12] && cmd_blk64 == cmd_addr[18:16])
      else $error("sector or block number wrong");
  AST_RESET_PULSE: assert property (soft_reset |-> chip_sel_n ##1 !soft_reset)
    else $error("soft reset pulse wrong");
  AST_OE_IN_FRAME: assert property ($rose(data_line_1_oe) |-> !chip_sel_n)
    else $error("output driven outside a frame");
  AST_OE_RELEASE: assert property (chip_sel_n [*6] |-> !data_line_1_oe)
    else $error("output not released after frame");
  COV_ERASE: cover property (cmd_exec && cmd_opcode == 8'h20);
  COV_RESET: cover property (soft_reset);
  COV_READ: cover property ($rose(data_line_1_oe));
endmodule // sfcf_frontend_checker

bind sfcf_frontend sfcf_frontend_checker chk_u (.clk_sys, .resetn, .chip_sel_n,
  .data_line_1_oe, .protect_bits, .write_latch_flag, .cmd_opcode, .cmd_addr,
  .cmd_sector, .cmd_blk64, .cmd_exec, .soft_reset);
`default_nettype wire

// ===== sfcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Serial host, 800 ns link clock, still between frames
module sfcf_host_model (
  input wire logic clk_sys,
  output logic chip_sel_n,
  output logic serial_clk,
  output logic data_line_0_in,
  input wire logic data_line_1_out,
  input wire logic data_line_1_oe
);
  logic idle_q;
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    data_line_0_in = 1'b0;
    idle_q = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic frame_on(input logic idle);
    idle_q = idle;
    serial_clk <= idle;
    hold(8);
    chip_sel_n <= 1'b0;
    hold(8);
  endtask
  // Sampling late in the high phase: output changes only after a seen fall
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - n; i--) begin
      serial_clk <= 1'b0;
      data_line_0_in <= tx[i];
      hold(4);
      serial_clk <= 1'b1;
      hold(3);
      rx[i] = data_line_1_oe ? data_line_1_out : 1'bx;
      hold(1);
    end
  endtask
  task automatic frame_off;
    serial_clk <= idle_q;
    hold(4);
    chip_sel_n <= 1'b1;
    data_line_0_in <= ~data_line_0_in;
    hold(8);
  endtask
endmodule // sfcf_host_model
`default_nettype wire

// ===== tb_serial_flash_command_frontend.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_command_frontend;
  // Identity values are arbitrary
  localparam logic [7:0] SIG = 8'h11;
  localparam logic [7:0] MKR = 8'h22;
  localparam logic [7:0] DEV = 8'h33;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] status_byte = 8'h00;
  logic [3:0] protect_bits = 4'h0;
  logic busy = 1'b0;
  logic [7:0] rd_data = 8'h00;
  wire chip_sel_n, serial_clk, host_d0, data_line_0_out, data_line_0_oe;
  wire data_line_1_out, data_line_1_oe, write_latch_flag, deep_sleep;
  wire cmd_exec, rd_req, wr_strobe, soft_reset;
  wire [7:0] cmd_opcode, wr_data;
  wire [23:0] cmd_addr;
  wire [6:0] cmd_sector;
  wire [3:0] cmd_blk32;
  wire [2:0] cmd_blk64;
  wire d0 = data_line_0_oe ? data_line_0_out : host_d0;
  wire d1 = data_line_1_oe ? data_line_1_out : 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  int execs = 0;
  int resets = 0;
  int oe_cnt = 0;
  int d0_cnt = 0;
  int strobes = 0;
  int rds = 0;
  logic [7:0] rx;
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    execs <= execs + (cmd_exec === 1'b1);
    resets <= resets + (soft_reset === 1'b1);
    oe_cnt <= oe_cnt + (data_line_1_oe === 1'b1);
    d0_cnt <= d0_cnt + (data_line_0_oe === 1'b1);
    strobes <= strobes + (wr_strobe === 1'b1);
    rds <= rds + (rd_req === 1'b1);
  end
  sfcf_frontend #(.SIG_ID(SIG), .MAKER_ID(MKR), .DEV_ID(DEV), .JEDEC_ID(24'h445566)) dut_u (
    .clk_sys, .resetn, .chip_sel_n, .serial_clk, .data_line_0_in(d0), .data_line_1_in(d1),
    .data_line_0_out, .data_line_0_oe, .data_line_1_out, .data_line_1_oe, .status_byte,
    .busy, .protect_bits, .write_latch_flag, .deep_sleep, .cmd_opcode, .cmd_addr,
    .cmd_sector, .cmd_blk32, .cmd_blk64, .cmd_exec, .rd_req, .rd_data, .wr_strobe,
    .wr_data, .soft_reset);
  sfcf_host_model host_u (.clk_sys, .chip_sel_n, .serial_clk, .data_line_0_in(host_d0),
    .data_line_1_out, .data_line_1_oe);
  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input logic idle, input logic [47:0] tx, input int nbits);
    host_u.frame_on(idle);
    for (int k = 0; k < nbits; k += 8)
      host_u.shift(tx[47-k -: 8], (nbits - k > 8) ? 8 : nbits - k, rx);
    host_u.frame_off();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_status;
    status_byte <= 8'h5c;
    run(1'b0, {8'h05, 40'h0}, 16);
    check("status mode 0", 8'h5c, rx);
    status_byte <= 8'ha3;
    run(1'b1, {8'h05, 40'h0}, 16);
    check("status mode 3", 8'ha3, rx);
    $display("test status done");
  endtask
  task automatic t_latch;
    int e;
    e = execs;
    run(1'b0, {8'h06, 40'h0}, 8);
    check("latch set", 1, write_latch_flag);
    check("set commit", e + 1, execs);
    run(1'b1, {8'h04, 40'h0}, 8);
    check("latch clear", 0, write_latch_flag);
    run(1'b0, {8'h06, 40'h0}, 7);
    check("short frame", 0, write_latch_flag);
    run(1'b0, {8'h06, 40'h0}, 9);
    check("long frame", 0, write_latch_flag);
    $display("test latch done");
  endtask
  task automatic t_erase;
    int e;
    e = execs;
    run(1'b0, {8'h20, 24'h07f123, 16'h0}, 32);
    check("erase unlatched", e, execs);
    run(1'b0, {8'h06, 40'h0}, 8);
    run(1'b0, {8'h20, 24'h07f123, 16'h0}, 32);
    check("erase commit", e + 2, execs);
    check("erase addr", 24'h07f123, cmd_addr);
    check("sector", 127, cmd_sector);
    check("half block", 15, cmd_blk32);
    check("block", 7, cmd_blk64);
    check("latch after", 0, write_latch_flag);
    protect_bits <= 4'h2;
    run(1'b0, {8'h06, 40'h0}, 8);
    run(1'b0, {8'h60, 40'h0}, 8);
    check("protected erase", e + 3, execs);
    protect_bits <= 4'h0;
    run(1'b0, {8'h06, 40'h0}, 8);
    run(1'b1, {8'hc7, 40'h0}, 8);
    check("chip erase", e + 5, execs);
    $display("test erase done");
  endtask
  task automatic t_ids;
    run(1'b0, {8'h90, 24'h000001, 16'h0}, 40);
    check("code dev first", DEV, rx);
    run(1'b1, {8'h90, 24'h000000, 16'h0}, 40);
    check("code maker first", MKR, rx);
    run(1'b0, {8'hab, 40'h0}, 40);
    check("signature", SIG, rx);
    run(1'b0, {8'hb9, 40'h0}, 8);
    check("sleep", 1, deep_sleep);
    run(1'b0, {8'hab, 40'h0}, 8);
    check("wake", 0, deep_sleep);
    $display("test ids done");
  endtask
  task automatic t_unknown;
    int o;
    o = oe_cnt;
    run(1'b0, {8'hff, 40'h0}, 16);
    check("standby output", o, oe_cnt);
    run(1'b0, {8'h05, 40'h0}, 16);
    check("next frame", 8'ha3, rx);
    $display("test unknown done");
  endtask
  task automatic t_soft_reset;
    int r;
    r = resets;
    run(1'b0, {8'h66, 40'h0}, 8);
    run(1'b0, {8'h99, 40'h0}, 8);
    check("reset pair", r + 1, resets);
    run(1'b0, {8'h66, 40'h0}, 8);
    run(1'b0, {8'h05, 40'h0}, 16);
    run(1'b0, {8'h99, 40'h0}, 8);
    check("reset split", r + 1, resets);
    $display("test soft reset done");
  endtask
  task automatic t_array;
    int e, s, r, o;
    e = execs;
    s = strobes;
    r = rds;
    o = d0_cnt;
    rd_data <= 8'h96;
    run(1'b1, {8'h0b, 24'h000010, 16'h0}, 48);
    check("fast read", 8'h96, rx);
    check("read request", 1, rds > r);
    check("line 0 idle single", o, d0_cnt);
    run(1'b0, {8'h3b, 24'h000010, 16'h0}, 44);
    check("dual line 1", 8'h90, rx);
    check("dual line 0 driven", 1, d0_cnt > o);
    run(1'b0, {8'h06, 40'h0}, 8);
    run(1'b0, {8'h02, 24'h000100, 8'hc3, 8'h00}, 40);
    check("program data", 8'hc3, wr_data);
    run(1'b0, {8'h06, 40'h0}, 8);
    run(1'b1, {8'h01, 8'h3c, 32'h0}, 16);
    check("status write data", 8'h3c, wr_data);
    check("write strobes", s + 2, strobes);
    check("latch after writes", 0, write_latch_flag);
    run(1'b0, {8'h41, 40'h0}, 8);
    check("write commits", e + 5, execs);
    busy <= 1'b1;
    o = oe_cnt;
    run(1'b0, {8'h03, 24'h000010, 16'h0}, 40);
    check("busy read ignored", o, oe_cnt);
    busy <= 1'b0;
    $display("test array done");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("latch at reset", 0, write_latch_flag);
    t_status();
    t_latch();
    t_erase();
    t_ids();
    t_unknown();
    t_soft_reset();
    t_array();
    end_of_test();
  end
  // Tests need about 6000 cycles; over six times that means a hang
  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end
endmodule // tb_serial_flash_command_frontend
`default_nettype wire
